// >>> serial_defs.vh
// Constants for the serial unit baud generator, queues and interrupt logic.
// Included by bare name by every design file of the block except the queue memory.
`ifndef SERIAL_DEFS_VH
`define SERIAL_DEFS_VH

// Register byte offsets
`define OFS_BAUD 8'h00
`define OFS_TX_HOLD 8'h04
`define OFS_RX_HOLD 8'h08
`define OFS_CONTROL 8'h0c
`define OFS_IRQ_EN 8'h10
`define OFS_FLAGS 8'h14
`define OFS_TX_FLUSH 8'h18
`define OFS_RX_FLUSH 8'h1c
`define OFS_GAP 8'h20

// Reset values
`define BAUD_RST 16'h0001
`define CONTROL_RST 16'h0000
`define IRQ_EN_RST 9'h000
`define GAP_RST 8'h00

// Control fields
`define CTL_MODE_LSB 0
`define CTL_MODE_MSB 2
`define CTL_RUN 7
`define CTL_FIFO_EN 10
`define CTL_MASK 16'h05ff

// Mode codes with a parity bit
`define MODE_7P 3'h3
`define MODE_8P 3'h7

// Flag positions
`define FL_RX_AVAIL 0
`define FL_TX_DRAINED 1
`define FL_TX_LOW 2
`define FL_PARITY 3
`define FL_FRAME 4
`define FL_OVERRUN 5
`define FL_GAP_DATA 6
`define FL_GAP_NODATA 7
`define FL_RX_HIGH 8
`define FL_TX_FULL 9
`define FLAG_W 10

// Queue sizes and thresholds
`define Q_DEPTH 16
`define Q_HALF 8
`define Q_CAP 5'h10
`define Q_HALF_CNT 5'h08
`define OVERSAMPLE 16
`define TX_W 9
`define RX_W 10

`endif

// >>> baud_divider.v
// Reloadable down counter that makes the oversampling tick.
// Assumes run, reload value and load strobe from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "serial_defs.vh"
module baud_divider (
  input wire core_clk,
  input wire rst,
  input wire run,
  input wire load,
  input wire [15:0] reload,
  output reg tick_r,
  output reg [15:0] count_r
);
  reg pend_r;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_r <= `BAUD_RST;
      pend_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (!run) begin
        // Frozen; a reload written now waits for run
        if (load)
          pend_r <= 1'b1;
      end else if (load || pend_r) begin
        count_r <= reload;
        pend_r <= 1'b0;
      end else if (count_r <= 16'h0001) begin
        count_r <= reload;
        tick_r <= 1'b1;
      end else begin
        count_r <= count_r - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> queue_mem.v
// Small queue memory with one write port and a registered read port.
// Assumes addresses and write enable from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none
module queue_mem #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data_r
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // No reset: contents are meaningless until written
  always @(posedge core_clk) begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data_r <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// >>> serial_core.v
// Baud generation, transmit and receive queues, flags and the interrupt of the serial unit.
// Assumes shifter and bus on core_clk; shifter signals need no synchronising.
`timescale 1ns/1ps
`default_nettype none
`include "serial_defs.vh"
// How it works
// - Divider makes an oversampling tick at sixteen times the baud rate.
// - Tick advances only while run bit is one.
// - Clearing run freezes shifters at once; software clears it only when idle.
// - Baud equals bus clock over sixteen times the unsigned 16-bit reload.
// - Divider runs from core_clk; no separate baud clock.
// - Exactly one interrupt output; flag register names the cause.
// - Interrupt is OR of flags 0 to 8 each ANDed with its enable bit; the transmit-full flag has no enable.
// - Flag register is read only; writes to it do nothing.
// - Any write to a flush register empties that queue and its flags.
// - Queues off: transmit-low flag rises when holding value moves to shifter.
// - Queues off: drained flag rises before stop bit, after data bits.
// - Queues off: data-available rises when a frame enters receive holding.
// - A new transmit write is taken while the previous one shifts out.
// - Queues on: sixteen transmit entries; low flag allows eight more writes.
// - Queues on: receive-high flag when at least eight characters wait.
// - After a reception gap one of two idle-gap flags rises by occupancy.
// - 8-bit gap counter reloads on read, start or write; else counts bauds.
// - Gap flags are counter zero with queue non-empty, or with queue empty.
// - Transmit queue of sixteen nine-bit entries; full flag at sixteen, or at one with queues off.
// - While run is zero the serial output holds the mark level.
module serial_core (
  input wire core_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_r,
  output reg [`TX_W-1:0] tx_data_r,
  output reg tx_valid_r,
  input wire tx_take,
  input wire tx_drained,
  input wire txd_in,
  input wire rx_start,
  input wire rx_push,
  input wire [`RX_W-1:0] rx_frame,
  output reg txd_r,
  output reg os_tick_r,
  output reg run_r,
  output reg [15:0] control_r,
  output reg serial_irq_r
);
  reg [15:0] baud_reload_value_r;
  reg [8:0] irq_enable_mask_r;
  reg [7:0] gap_reload_value_r;
  reg [7:0] gap_cnt_r;
  reg [3:0] sub_cnt_r;
  reg [3:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  reg [4:0] tx_cnt_r, rx_cnt_r;
  reg [4:0] fe_cnt_r, pe_cnt_r;
  reg overrun_r;
  reg tx_settle_r;
  reg [`FLAG_W-1:0] flags;
  reg [4:0] tx_cnt_nxt;
  reg [4:0] rx_cnt_nxt;

  wire tick;
  wire [15:0] baud_count;
  wire [`RX_W-1:0] rx_head;
  wire [`TX_W-1:0] tx_head;
  wire fifo_en = control_r[`CTL_FIFO_EN];
  wire run = control_r[`CTL_RUN];
  wire [2:0] mode = control_r[`CTL_MODE_MSB:`CTL_MODE_LSB];
  wire [4:0] q_cap = fifo_en ? `Q_CAP : 5'h01;
  wire wr_baud = reg_wr && reg_addr == `OFS_BAUD;
  wire wr_tx = reg_wr && reg_addr == `OFS_TX_HOLD;
  wire wr_ctl = reg_wr && reg_addr == `OFS_CONTROL;
  wire wr_ie = reg_wr && reg_addr == `OFS_IRQ_EN;
  wire wr_gap = reg_wr && reg_addr == `OFS_GAP;
  wire tx_flush = reg_wr && reg_addr == `OFS_TX_FLUSH;
  wire rx_flush = reg_wr && reg_addr == `OFS_RX_FLUSH;
  wire rd_rx = reg_rd && reg_addr == `OFS_RX_HOLD;
  wire tx_full = tx_cnt_r == q_cap;
  wire rx_full = rx_cnt_r == q_cap;
  // Queues off and full: a write overwrites the single held value
  wire tx_overwrite = wr_tx && tx_full && !fifo_en;
  wire tx_put = wr_tx && !tx_full && !tx_flush;
  wire tx_pop = tx_take && tx_valid_r && !tx_flush;
  wire rx_put = rx_push && !rx_full && !rx_flush;
  wire rx_pop = rd_rx && rx_cnt_r != 5'h00 && !rx_flush;
  wire baud_tick = tick && sub_cnt_r == 4'hf;
  wire [3:0] tx_waddr = tx_overwrite ? tx_rp_r : tx_wp_r;
  // Head slot changed: its data reach tx_data_r only two edges later
  wire tx_fresh = tx_pop || tx_flush || tx_overwrite || (tx_put && tx_cnt_r == 5'h00);

  // Which stored bit carries the parity error for the current mode
  function par_err;
    input [2:0] m;
    input [`RX_W-1:0] f;
    begin
      if (m == `MODE_8P)
        par_err = f[8];
      else if (m == `MODE_7P)
        par_err = f[7];
      else
        par_err = 1'b0;
    end
  endfunction

  baud_divider u_baud (
    .core_clk(core_clk),
    .rst(rst),
    .run(run),
    .load(wr_baud),
    .reload(baud_reload_value_r),
    .tick_r(tick),
    .count_r(baud_count)
  );

  queue_mem #(.WIDTH(`TX_W), .DEPTH(`Q_DEPTH), .AW(4)) u_txq (
    .core_clk(core_clk),
    .wr_en(tx_put || tx_overwrite),
    .wr_addr(tx_waddr),
    .wr_data(reg_wdata[`TX_W-1:0]),
    .rd_addr(tx_rp_r),
    .rd_data_r(tx_head)
  );

  queue_mem #(.WIDTH(`RX_W), .DEPTH(`Q_DEPTH), .AW(4)) u_rxq (
    .core_clk(core_clk),
    .wr_en(rx_put),
    .wr_addr(rx_wp_r),
    .wr_data(rx_frame),
    .rd_addr(rx_rp_r),
    .rd_data_r(rx_head)
  );

  always @* begin
    tx_cnt_nxt = tx_cnt_r;
    if (tx_put && !tx_pop)
      tx_cnt_nxt = tx_cnt_r + 5'h01;
    else if (tx_pop && !tx_put)
      tx_cnt_nxt = tx_cnt_r - 5'h01;
    rx_cnt_nxt = rx_cnt_r;
    if (rx_put && !rx_pop)
      rx_cnt_nxt = rx_cnt_r + 5'h01;
    else if (rx_pop && !rx_put)
      rx_cnt_nxt = rx_cnt_r - 5'h01;
  end

  always @* begin
    flags = {`FLAG_W{1'b0}};
    flags[`FL_TX_FULL] = tx_full;
    flags[`FL_RX_HIGH] = fifo_en && rx_cnt_r >= `Q_HALF_CNT;
    flags[`FL_GAP_NODATA] = gap_cnt_r == 8'h00 && rx_cnt_r == 5'h00;
    flags[`FL_GAP_DATA] = gap_cnt_r == 8'h00 && rx_cnt_r != 5'h00;
    flags[`FL_OVERRUN] = overrun_r;
    flags[`FL_FRAME] = fe_cnt_r != 5'h00;
    flags[`FL_PARITY] = pe_cnt_r != 5'h00;
    // Queues off the held value leaves at once on the shifter's take
    flags[`FL_TX_LOW] = fifo_en ? tx_cnt_r <= `Q_HALF_CNT : tx_cnt_r == 5'h00;
    flags[`FL_TX_DRAINED] = tx_drained;
    flags[`FL_RX_AVAIL] = rx_cnt_r != 5'h00;
  end

  // Registers
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      baud_reload_value_r <= `BAUD_RST;
      control_r <= `CONTROL_RST;
      irq_enable_mask_r <= `IRQ_EN_RST;
      gap_reload_value_r <= `GAP_RST;
    end else begin
      if (wr_baud)
        baud_reload_value_r <= reg_wdata;
      if (wr_ctl)
        control_r <= reg_wdata & `CTL_MASK;
      if (wr_ie)
        irq_enable_mask_r <= reg_wdata[8:0];
      if (wr_gap)
        gap_reload_value_r <= reg_wdata[7:0];
    end
  end

  // Queue pointers and error bookkeeping
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_wp_r <= 4'h0;
      tx_rp_r <= 4'h0;
      tx_cnt_r <= 5'h00;
      rx_wp_r <= 4'h0;
      rx_rp_r <= 4'h0;
      rx_cnt_r <= 5'h00;
      fe_cnt_r <= 5'h00;
      pe_cnt_r <= 5'h00;
      overrun_r <= 1'b0;
    end else begin
      if (tx_flush) begin
        tx_wp_r <= 4'h0;
        tx_rp_r <= 4'h0;
        tx_cnt_r <= 5'h00;
      end else begin
        if (tx_put)
          tx_wp_r <= tx_wp_r + 4'h1;
        if (tx_pop)
          tx_rp_r <= tx_rp_r + 4'h1;
        tx_cnt_r <= tx_cnt_nxt;
      end
      if (rx_flush) begin
        rx_wp_r <= 4'h0;
        rx_rp_r <= 4'h0;
        rx_cnt_r <= 5'h00;
        fe_cnt_r <= 5'h00;
        pe_cnt_r <= 5'h00;
        overrun_r <= 1'b0;
      end else begin
        if (rx_put)
          rx_wp_r <= rx_wp_r + 4'h1;
        if (rx_pop)
          rx_rp_r <= rx_rp_r + 4'h1;
        rx_cnt_r <= rx_cnt_nxt;
        fe_cnt_r <= fe_cnt_r + {4'h0, rx_put && rx_frame[9]}
          - {4'h0, rx_pop && rx_head[9]};
        pe_cnt_r <= pe_cnt_r + {4'h0, rx_put && par_err(mode, rx_frame)}
          - {4'h0, rx_pop && par_err(mode, rx_head)};
        // Set beats the clear from a read in the same cycle
        if (rx_push && rx_full)
          overrun_r <= 1'b1;
        else if (rd_rx)
          overrun_r <= 1'b0;
      end
    end
  end

  // Gap counter, counted in whole bit times
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sub_cnt_r <= 4'h0;
      gap_cnt_r <= `GAP_RST;
    end else begin
      if (tick)
        sub_cnt_r <= sub_cnt_r + 4'h1;
      if (rd_rx || rx_start || wr_gap)
        gap_cnt_r <= wr_gap ? reg_wdata[7:0] : gap_reload_value_r;
      else if (baud_tick && gap_cnt_r != 8'h00)
        gap_cnt_r <= gap_cnt_r - 8'h01;
    end
  end

  // Outputs to the shifter, line and interrupt controller
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_data_r <= {`TX_W{1'b0}};
      tx_valid_r <= 1'b0;
      tx_settle_r <= 1'b0;
      txd_r <= 1'b1;
      os_tick_r <= 1'b0;
      run_r <= 1'b0;
      serial_irq_r <= 1'b0;
    end else begin
      tx_data_r <= tx_head;
      // Valid waits out the two-edge head latency so stale data are never offered
      tx_settle_r <= tx_fresh;
      tx_valid_r <= tx_cnt_r != 5'h00 && !tx_fresh && !tx_settle_r;
      txd_r <= run ? txd_in : 1'b1;
      os_tick_r <= tick;
      run_r <= run;
      serial_irq_r <= |(flags[8:0] & irq_enable_mask_r);
    end
  end

  // Register read port; flag register has no write decode
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_BAUD: reg_rdata_r <= baud_count;
        `OFS_RX_HOLD: reg_rdata_r <= {6'h00, rx_head};
        `OFS_CONTROL: reg_rdata_r <= control_r;
        `OFS_IRQ_EN: reg_rdata_r <= {7'h00, irq_enable_mask_r};
        `OFS_FLAGS: reg_rdata_r <= {6'h00, flags};
        `OFS_GAP: reg_rdata_r <= {8'h00, gap_reload_value_r};
        default: reg_rdata_r <= 16'h0000;
      endcase
    end else begin
      reg_rdata_r <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// >>> serial_core_assertions.sv
// Port checks on serial_core: tick timing, idle line, bus reads, mask.
// Assumes a bind to serial_core and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "serial_defs.vh"
module serial_core_assertions (
  input wire core_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata_r,
  input wire tx_valid_r,
  input wire tx_take,
  input wire txd_r,
  input wire os_tick_r,
  input wire run_r,
  input wire [15:0] control_r,
  input wire serial_irq_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [15:0] rl_r;
  logic [15:0] since_r;
  logic dirty_r;
  wire bw = reg_wr && reg_addr == `OFS_BAUD;
  wire mw = reg_wr && reg_addr == `OFS_IRQ_EN;
  wire cw = reg_wr && reg_addr == `OFS_CONTROL;
  wire fr = reg_rd && reg_addr == `OFS_FLAGS;
  // Interval is only trusted after one clean tick past a reload or stop
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rl_r <= `BAUD_RST;
      since_r <= 16'h0000;
      dirty_r <= 1'b1;
    end else begin
      if (bw) begin
        rl_r <= reg_wdata;
      end
      since_r <= os_tick_r ? 16'h0001 : since_r + 16'h0001;
      dirty_r <= (bw || !run_r) ? 1'b1 : (os_tick_r ? 1'b0 : dirty_r);
    end
  end
  property p_period;
    os_tick_r && !dirty_r && rl_r > 16'h0001 |-> since_r == rl_r;
  endproperty
  a_period: assert property (p_period)
    else $error("tick interval differs from reload");
  property p_late;
    run_r && control_r[`CTL_RUN] && !dirty_r && rl_r > 16'h0001 |-> since_r <= rl_r;
  endproperty
  a_late: assert property (p_late)
    else $error("tick missing after reload interval");
  property p_stop;
    (!control_r[`CTL_RUN]) [*3] |-> !os_tick_r;
  endproperty
  a_stop: assert property (p_stop)
    else $error("tick while stopped");
  property p_mark;
    (!run_r) [*2] |-> txd_r;
  endproperty
  a_mark: assert property (p_mark)
    else $error("serial line not idle while stopped");
  property p_mask;
    mw && reg_wdata[8:0] == 9'h000 ##1 !mw |=> !serial_irq_r;
  endproperty
  a_mask: assert property (p_mask)
    else $error("irq high with empty mask");
  property p_ctl;
    cw |=> control_r == ($past(reg_wdata) & `CTL_MASK);
  endproperty
  a_ctl: assert property (p_ctl)
    else $error("control write not taken");
  property p_rdz;
    !$past(reg_rd) |-> reg_rdata_r == 16'h0000;
  endproperty
  a_rdz: assert property (p_rdz)
    else $error("read data outside read slot");
  property p_fhi;
    $past(fr) |-> reg_rdata_r[15:10] == 6'h00;
  endproperty
  a_fhi: assert property (p_fhi)
    else $error("flag read upper bits set");
  property p_take;
    tx_take && tx_valid_r |=> !tx_valid_r;
  endproperty
  a_take: assert property (p_take)
    else $error("head still valid after take");
  c_tick: cover property (os_tick_r);
  c_irq: cover property (!serial_irq_r ##1 serial_irq_r);
  c_take: cover property (tx_take && tx_valid_r);
endmodule
bind serial_core serial_core_assertions u_chk (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .tx_valid_r(tx_valid_r),
  .tx_take(tx_take), .txd_r(txd_r), .os_tick_r(os_tick_r), .run_r(run_r),
  .control_r(control_r), .serial_irq_r(serial_irq_r)
);
`default_nettype wire

// >>> irq_sink.sv
// Interrupt controller model: level input, pending copy, rise count.
// Assumes the irq level is synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module irq_sink (
  input wire core_clk,
  input wire rst,
  input wire serial_irq,
  output logic pending_r,
  output logic [7:0] rises_r
);
  logic seen_r;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seen_r <= 1'b0;
      pending_r <= 1'b0;
      rises_r <= 8'h00;
    end else begin
      seen_r <= serial_irq;
      pending_r <= serial_irq;
      if (serial_irq && !seen_r) begin
        rises_r <= rises_r + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_serial_core.sv
// Self-checking bench for serial_core: bus, tick, irq and queues.
// Assumes serial_defs.vh, irq_sink and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "serial_defs.vh"
module tb_serial_core;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, tx_take = 0;
  logic tx_drained = 1, txd_in = 1, rx_start = 0, rx_push = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, rdata;
  logic [9:0] rx_frame = 10'h000;
  wire [15:0] reg_rdata_r, control_r;
  wire [8:0] tx_data_r;
  wire tx_valid_r, txd_r, os_tick_r, run_r, serial_irq_r, pend;
  wire [7:0] rises;
  int fails = 0, check_count = 0, cyc = 0, n;
  serial_core DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .tx_data_r(tx_data_r), .tx_valid_r(tx_valid_r), .tx_take(tx_take),
    .tx_drained(tx_drained), .txd_in(txd_in), .rx_start(rx_start), .rx_push(rx_push),
    .rx_frame(rx_frame), .txd_r(txd_r), .os_tick_r(os_tick_r), .run_r(run_r),
    .control_r(control_r), .serial_irq_r(serial_irq_r));
  irq_sink u_sink (.core_clk(core_clk), .rst(rst), .serial_irq(serial_irq_r),
    .pending_r(pend), .rises_r(rises));
  initial forever #25 core_clk = ~core_clk;
  task final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Whole run needs about 210 cycles
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      final_report();
    end
  end
  task chk(input string nm, input [15:0] e, input [15:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge core_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1; end
    @(posedge core_clk) reg_wr <= 0;
  endtask
  task rd(input [7:0] a);
    @(posedge core_clk) begin reg_addr <= a; reg_rd <= 1; end
    @(posedge core_clk) reg_rd <= 0;
    #1 rdata = reg_rdata_r;
  endtask
  task flags(input [15:0] m, input [15:0] e, input string nm);
    rd(`OFS_FLAGS);
    chk(nm, e, rdata & m);
  endtask
  task push(input [9:0] f);
    @(posedge core_clk) rx_start <= 1;
    @(posedge core_clk) begin rx_start <= 0; rx_frame <= f; rx_push <= 1; end
    @(posedge core_clk) rx_push <= 0;
  endtask
  task take_head(input [8:0] e);
    #1;
    n = 0;
    while (tx_valid_r !== 1'b1 && n < 8) begin @(posedge core_clk); #1 n++; end
    chk("tx head", {7'h00, e}, {7'h00, tx_data_r});
    @(posedge core_clk) tx_take <= 1;
    @(posedge core_clk) tx_take <= 0;
  endtask
  task t_reset;
    flags(16'h03ff, 16'h0086, "reset flags");
    chk("reset outs", 16'h0008, {11'h000, tx_valid_r, txd_r, run_r, serial_irq_r, os_tick_r});
    chk("control reset", 16'h0000, control_r);
    rd(`OFS_IRQ_EN);
    chk("mask reset", 16'h0000, rdata);
    wr(`OFS_FLAGS, 16'hffff);
    flags(16'hffff, 16'h0086, "flag write");
    rd(8'h24);
    chk("unmapped", 16'h0000, rdata);
    $display("test reset done");
  endtask
  task t_tick;
    wr(`OFS_BAUD, 16'h0003);
    @(posedge core_clk) txd_in <= 0;
    n = 0;
    repeat (12) begin @(posedge core_clk); #1 n += os_tick_r; end
    chk("ticks stopped", 16'h0000, n[15:0]);
    chk("mark idle", 16'h0001, {15'h0, txd_r});
    wr(`OFS_CONTROL, 16'h0080);
    repeat (4) @(posedge core_clk);
    n = 0;
    // Thirty cycles hold exactly ten periods of three whatever the phase
    repeat (30) begin @(posedge core_clk); #1 n += os_tick_r; end
    chk("ticks run", 16'h000a, n[15:0]);
    chk("run copy", 16'h0001, {15'h0, run_r});
    chk("line follows", 16'h0000, {15'h0, txd_r});
    chk("control run", 16'h0080, control_r);
    wr(`OFS_CONTROL, 16'h0000);
    txd_in <= 1;
    repeat (2) @(posedge core_clk);
    #1 chk("run off", 16'h0000, {15'h0, run_r});
    $display("test tick done");
  endtask
  task t_irq;
    wr(`OFS_IRQ_EN, 16'h0080);
    repeat (3) @(posedge core_clk);
    #1 chk("irq gap", 16'h0001, {15'h0, serial_irq_r});
    chk("pending", 16'h0001, {15'h0, pend});
    @(posedge core_clk) tx_drained <= 0;
    wr(`OFS_IRQ_EN, 16'h0002);
    repeat (3) @(posedge core_clk);
    #1 chk("irq masked", 16'h0000, {15'h0, serial_irq_r});
    @(posedge core_clk) tx_drained <= 1;
    repeat (4) @(posedge core_clk);
    #1 chk("irq drained", 16'h0001, {15'h0, serial_irq_r});
    wr(`OFS_IRQ_EN, 16'h0000);
    #1 chk("irq rises", 16'h0002, {8'h00, rises});
    $display("test irq done");
  endtask
  task t_tx;
    wr(`OFS_TX_HOLD, 16'h00a5);
    flags(16'h0004, 16'h0000, "tx low held");
    take_head(9'h0a5);
    flags(16'h0004, 16'h0004, "tx low moved");
    tx_drained <= 0;
    wr(`OFS_TX_HOLD, 16'h015a);
    take_head(9'h15a);
    tx_drained <= 1;
    flags(16'h0002, 16'h0002, "drained end");
    $display("test tx done");
  endtask
  task t_rx;
    push(10'h055);
    repeat (2) @(posedge core_clk);
    flags(16'h00c1, 16'h0041, "rx avail");
    rd(`OFS_RX_HOLD);
    chk("rx data", 16'h0055, rdata);
    flags(16'h00c1, 16'h0080, "rx empty");
    $display("test rx done");
  endtask
  task t_fifo;
    wr(`OFS_CONTROL, 16'h0400);
    wr(`OFS_TX_FLUSH, 16'h0000);
    wr(`OFS_RX_FLUSH, 16'h0000);
    repeat (7) push(10'h011);
    flags(16'h0100, 16'h0000, "rx seven");
    push(10'h022);
    flags(16'h0100, 16'h0100, "rx eight");
    wr(`OFS_RX_FLUSH, 16'h0000);
    flags(16'h01c1, 16'h0080, "rx flush");
    repeat (8) wr(`OFS_TX_HOLD, 16'h0033);
    flags(16'h0204, 16'h0004, "tx eight");
    wr(`OFS_TX_HOLD, 16'h0044);
    flags(16'h0204, 16'h0000, "tx nine");
    repeat (7) wr(`OFS_TX_HOLD, 16'h0055);
    flags(16'h0204, 16'h0200, "tx full");
    wr(`OFS_TX_FLUSH, 16'h0000);
    flags(16'h0204, 16'h0004, "tx flush");
    wr(`OFS_TX_HOLD, 16'h0066);
    wr(`OFS_TX_HOLD, 16'h0077);
    take_head(9'h066);
    take_head(9'h077);
    $display("test fifo done");
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 0;
    t_reset;
    t_tick;
    t_irq;
    t_tx;
    t_rx;
    t_fifo;
    final_report;
  end
endmodule
`default_nettype wire
